/* rtl/video_tx_status_pkg.sv */
/*
  Constants for the video transmit status monitor: register map, field
  positions, reset values and pixel clock measurement timing.
  Assumes a 125 MHz core clock and a byte-wide register port.
*/
// Operation
// - pixel clock detected only when receiver recovers a clock above 4 MHz.
// - detection works and is reported the same in every video mode.
// - after pipeline start, drift beyond +/-1.25 percent raises drift flag until restart.
// - overflow flag set whenever the transmit FIFO overflows.
// - FIFO warning shows one while occupancy exceeds half capacity, and stays one through the first status read after it falls.
// - writable bit 2: one suppresses heartbeat during blanking, zero keeps it.
// - readable phy, protocol and tunnel packet counters show input data arriving, tunnel packets only in tunnel mode.
package video_tx_status_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int PKT_CNT_W = 16;
  localparam int NUM_PKT_CNT = 3;

  // register map, byte addresses
  localparam logic [ADDR_W-1:0] VIDEO_TX_STATUS_ADDR = 12'h112;
  localparam logic [ADDR_W-1:0] PKT_CNT_BASE_ADDR = 12'h120;

  // video_tx_status fields
  localparam int PCLK_DET_BIT = 7;
  localparam int DRIFT_ERR_BIT = 6;
  localparam int OVERFLOW_BIT = 5;
  localparam int FIFO_WARN_BIT = 4;
  localparam int RSVD3_BIT = 3;
  localparam int HEARTBEAT_OFF_BIT = 2;
  localparam int RSVD1_BIT = 1;

  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h0A;
  localparam logic HEARTBEAT_OFF_RESET = 1'b0;

  // pixel clock measurement
  localparam longint CLK_FREQ_HZ = 125_000_000;
  localparam longint MIN_PCLK_HZ = 4_000_000;
  localparam longint GATE_TIME_US = 100;
  localparam int GATE_CYCLES = int'(GATE_TIME_US * CLK_FREQ_HZ / 1_000_000);
  localparam longint DRIFT_TOL_NUM = 125;
  localparam longint DRIFT_TOL_DEN = 10_000;

  localparam int FIFO_DEPTH = 256;

endpackage

/* rtl/pclk_status_if.sv */
/*
  Carrier between the pixel clock meter and the status register logic.
  Assumes both ends share sys_clk.
*/
`timescale 1ns/1ps
interface pclk_status_if;
  logic detected;
  logic drift_event;

  modport meter (output detected, output drift_event);
  modport monitor (input detected, input drift_event);
endinterface

/* rtl/pclk_freq_meter.sv */
/*
  Pixel clock frequency meter: counts pixel clock events in a fixed gate,
  flags presence above the minimum rate and drift against a reference
  taken at pipeline start.
  Assumes pclk_event is a one-cycle pulse per pixel clock, synchronous
  to sys_clk.
*/
`timescale 1ns/1ps
module pclk_freq_meter
  import video_tx_status_pkg::*;
#(
  parameter int GATE_CYC = video_tx_status_pkg::GATE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pclk_event,
  input wire logic pclk_lock,
  input wire logic pipeline_running,
  pclk_status_if.meter st
);
  import video_tx_status_pkg::*;

  localparam int CNT_W = $clog2(GATE_CYC + 1);
  localparam longint MIN_COUNT = MIN_PCLK_HZ * GATE_CYC / CLK_FREQ_HZ;

  generate
    if (GATE_CYC < 2 || MIN_COUNT < 1) begin : g_bad_gate
      $error("gate too short to measure the minimum pixel clock");
    end
  endgenerate

  logic [CNT_W-1:0] gate_q;
  logic [CNT_W-1:0] edges_q;
  logic [CNT_W-1:0] ref_q;
  logic ref_valid_q;
  logic drift_lock_q;
  logic detected_q;
  logic drift_event_q;
  logic window_end;
  logic [CNT_W-1:0] diff;
  logic out_of_range;

  assign window_end = (gate_q == '0);
  assign diff = (edges_q > ref_q) ? edges_q - ref_q : ref_q - edges_q;
  assign out_of_range = (longint'(diff) * DRIFT_TOL_DEN) > (longint'(ref_q) * DRIFT_TOL_NUM);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= '0;
    end else if (window_end) begin
      gate_q <= CNT_W'(GATE_CYC - 1);
    end else begin
      gate_q <= gate_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edges_q <= '0;
    end else if (window_end) begin
      edges_q <= {{(CNT_W-1){1'b0}}, pclk_event};
    end else if (pclk_event) begin
      edges_q <= edges_q + 1'b1;
    end
  end

  // no mode input on purpose: detection is identical in every video mode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      detected_q <= 1'b0;
    end else if (!pclk_lock) begin
      detected_q <= 1'b0;
    end else if (window_end) begin
      detected_q <= longint'(edges_q) > MIN_COUNT;
    end
  end

  // reference caught on the first full window after start; restart clears it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_q <= '0;
      ref_valid_q <= 1'b0;
    end else if (!pipeline_running) begin
      ref_valid_q <= 1'b0;
    end else if (window_end && !ref_valid_q && detected_q) begin
      ref_q <= edges_q;
      ref_valid_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drift_lock_q <= 1'b0;
      drift_event_q <= 1'b0;
    end else if (!pipeline_running) begin
      drift_lock_q <= 1'b0;
      drift_event_q <= 1'b0;
    end else begin
      drift_event_q <= window_end && ref_valid_q && (out_of_range || drift_lock_q);
      if (window_end && ref_valid_q && out_of_range) begin
        drift_lock_q <= 1'b1;
      end
    end
  end

  assign st.detected = detected_q;
  assign st.drift_event = drift_event_q;

endmodule

/* rtl/packet_counters.sv */
/*
  Free-running wrap-around packet counters, one per input layer.
  Assumes each count input is a one-cycle pulse per packet.
*/
`timescale 1ns/1ps
module packet_counters
  import video_tx_status_pkg::*;
#(
  parameter int N = video_tx_status_pkg::NUM_PKT_CNT,
  parameter int W = video_tx_status_pkg::PKT_CNT_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [N-1:0] count_pulse,
  output logic [N-1:0][W-1:0] count
);
  import video_tx_status_pkg::*;

  generate
    if (N < 1 || W < 8) begin : g_bad_cnt
      $error("packet counters need at least one counter of 8 bits");
    end
    for (genvar i = 0; i < N; i++) begin : g_cnt
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          count[i] <= '0;
        end else if (count_pulse[i]) begin
          count[i] <= count[i] + 1'b1;
        end
      end
    end
  endgenerate

endmodule

/* rtl/video_tx_status_monitor.sv */
/*
  Status and health monitor of the video transmit path: pixel clock
  presence and drift, transmit FIFO overflow and half-full warning,
  blanking heartbeat control and readable packet counters.
  Assumes a single sys_clk domain, inputs synchronous to it, and a byte
  register port with read data one cycle after the read strobe.
*/
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module video_tx_status_monitor
  import video_tx_status_pkg::*;
#(
  parameter int GATE_CYC = video_tx_status_pkg::GATE_CYCLES,
  parameter int FIFO_DEP = video_tx_status_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [video_tx_status_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [video_tx_status_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [video_tx_status_pkg::DATA_W-1:0] reg_rdata,
  // video input receiver
  input wire logic pclk_event,
  input wire logic pclk_lock,
  input wire logic pipeline_running,
  input wire logic blanking,
  input wire logic tunnel_mode,
  input wire logic phy_packet,
  input wire logic protocol_packet,
  input wire logic tunnel_packet,
  // video transmit FIFO
  input wire logic fifo_push,
  input wire logic fifo_full,
  input wire logic [$clog2(FIFO_DEP+1)-1:0] fifo_level,
  // link
  output logic heartbeat_enable
);
  import video_tx_status_pkg::*;

  localparam int LVL_W = $clog2(FIFO_DEP + 1);
  localparam logic [LVL_W-1:0] HALF_LEVEL = LVL_W'(FIFO_DEP / 2);
  localparam int CNT_BYTES = PKT_CNT_W / DATA_W;

  generate
    if (FIFO_DEP < 2) begin : g_bad_fifo
      $error("FIFO depth must be at least 2");
    end
    if (PKT_CNT_W % DATA_W != 0) begin : g_bad_width
      $error("packet counter width must be whole bytes");
    end
  endgenerate

  pclk_status_if pclk_st ();

  pclk_freq_meter #(
    .GATE_CYC(GATE_CYC)
  ) u_meter (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pclk_event(pclk_event),
    .pclk_lock(pclk_lock),
    .pipeline_running(pipeline_running),
    .st(pclk_st.meter)
  );

  logic [NUM_PKT_CNT-1:0] pkt_pulse;
  logic [NUM_PKT_CNT-1:0][PKT_CNT_W-1:0] pkt_count;

  // tunnel packets only counted in tunneling mode
  assign pkt_pulse = {tunnel_packet && tunnel_mode, protocol_packet, phy_packet};

  packet_counters #(
    .N(NUM_PKT_CNT),
    .W(PKT_CNT_W)
  ) u_counters (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .count_pulse(pkt_pulse),
    .count(pkt_count)
  );

  // address decode
  logic status_sel;
  logic status_rd;
  logic status_wr;
  logic cnt_sel;
  logic [ADDR_W-1:0] cnt_offset;
  logic [$clog2(NUM_PKT_CNT*CNT_BYTES+1)-1:0] cnt_byte;

  assign status_sel = (reg_addr == VIDEO_TX_STATUS_ADDR);
  assign status_rd = reg_rd && status_sel;
  assign status_wr = reg_wr && status_sel;
  assign cnt_offset = reg_addr - PKT_CNT_BASE_ADDR;
  assign cnt_sel = (reg_addr >= PKT_CNT_BASE_ADDR)
    && (cnt_offset < ADDR_W'(NUM_PKT_CNT * CNT_BYTES));
  assign cnt_byte = cnt_offset[$clog2(NUM_PKT_CNT*CNT_BYTES+1)-1:0];

  // event sources
  logic overflow_event;
  logic warn_now;

  assign overflow_event = fifo_push && fifo_full;
  assign warn_now = fifo_level > HALF_LEVEL;

  // sticky flags; a same-cycle event beats the read-clear
  logic drift_q;
  logic overflow_q;
  logic warn_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drift_q <= STATUS_RESET[DRIFT_ERR_BIT];
    end else if (pclk_st.drift_event) begin
      drift_q <= 1'b1;
    end else if (status_rd) begin
      drift_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_q <= STATUS_RESET[OVERFLOW_BIT];
    end else if (overflow_event) begin
      overflow_q <= 1'b1;
    end else if (status_rd) begin
      overflow_q <= 1'b0;
    end
  end

  // warning latches a brief crossing; live level keeps it visible meanwhile
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      warn_q <= STATUS_RESET[FIFO_WARN_BIT];
    end else if (warn_now) begin
      warn_q <= 1'b1;
    end else if (status_rd) begin
      warn_q <= 1'b0;
    end
  end

  // heartbeat control bit
  logic heartbeat_off_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      heartbeat_off_q <= HEARTBEAT_OFF_RESET;
    end else if (status_wr) begin
      heartbeat_off_q <= reg_wdata[HEARTBEAT_OFF_BIT];
    end
  end

  // the far deserializer must be configured to tolerate the missing beats
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      heartbeat_enable <= 1'b1;
    end else begin
      heartbeat_enable <= !(heartbeat_off_q && blanking);
    end
  end

  // status byte as software sees it
  logic [DATA_W-1:0] status_view;

  always_comb begin
    status_view = STATUS_RESET;
    status_view[PCLK_DET_BIT] = pclk_st.detected;
    status_view[DRIFT_ERR_BIT] = drift_q;
    status_view[OVERFLOW_BIT] = overflow_q;
    status_view[FIFO_WARN_BIT] = warn_q || warn_now;
    status_view[HEARTBEAT_OFF_BIT] = heartbeat_off_q;
  end

  // high bytes snapped on the low-byte read so a 16-bit value never tears
  logic [NUM_PKT_CNT-1:0][PKT_CNT_W-DATA_W-1:0] hi_snap_q;

  generate
    for (genvar i = 0; i < NUM_PKT_CNT; i++) begin : g_snap
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          hi_snap_q[i] <= '0;
        end else if (reg_rd && cnt_sel && cnt_byte == ($bits(cnt_byte))'(i * CNT_BYTES)) begin
          hi_snap_q[i] <= pkt_count[i][PKT_CNT_W-1:DATA_W];
        end
      end
    end
  endgenerate

  // counter byte selection, low byte live, upper bytes from the snapshot
  logic [DATA_W-1:0] cnt_view;
  logic [PKT_CNT_W-1:0] cnt_word;

  always_comb begin
    cnt_view = '0;
    cnt_word = '0;
    for (int i = 0; i < NUM_PKT_CNT; i++) begin
      if (cnt_byte / CNT_BYTES == i) begin
        cnt_word = {hi_snap_q[i], pkt_count[i][DATA_W-1:0]};
      end
    end
    for (int b = 0; b < CNT_BYTES; b++) begin
      if (cnt_byte % CNT_BYTES == b) begin
        cnt_view = cnt_word[b*DATA_W +: DATA_W];
      end
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (status_sel) begin
        reg_rdata <= status_view;
      end else if (cnt_sel) begin
        reg_rdata <= cnt_view;
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

/* testbench/video_tx_status_monitor_checker.sv */
/*
  Port assertions of the video transmit status monitor.
  Assumes one sys_clk domain; bound from the bench top file.
*/
`timescale 1ns/1ps
module video_tx_status_monitor_checker
  import video_tx_status_pkg::*;
#(
  parameter int GATE_CYC = video_tx_status_pkg::GATE_CYCLES,
  parameter int FIFO_DEP = video_tx_status_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [video_tx_status_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [video_tx_status_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [video_tx_status_pkg::DATA_W-1:0] reg_rdata,
  input wire logic pclk_lock,
  input wire logic blanking,
  input wire logic fifo_push,
  input wire logic fifo_full,
  input wire logic [$clog2(FIFO_DEP+1)-1:0] fifo_level,
  input wire logic heartbeat_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic rd_st;
  logic ovf;
  assign rd_st = reg_rd && reg_addr == VIDEO_TX_STATUS_ADDR;
  assign ovf = fifo_push && fifo_full;

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside the answer cycle");
  hb_follow_a: assert property (!$past(blanking) |-> heartbeat_enable)
    else $error("heartbeat off outside blanking");
  hb_off_a: assert property ((reg_wr && reg_addr == VIDEO_TX_STATUS_ADDR && reg_wdata[2])
    ##1 (blanking && !reg_wr)[*2] |=> !heartbeat_enable)
    else $error("heartbeat not suppressed in blanking");
  overflow_a: assert property (ovf ##1 !rd_st ##1 rd_st |=> reg_rdata[5])
    else $error("overflow flag missing");
  warn_level_a: assert property (rd_st && fifo_level > FIFO_DEP / 2 |=> reg_rdata[4])
    else $error("fifo warning missing above half");
  pclk_none_a: assert property (rd_st && !pclk_lock && !$past(pclk_lock) |=> !reg_rdata[7])
    else $error("pixel clock shown without lock");
  fixed_bits_a: assert property (rd_st |=> reg_rdata[3] && reg_rdata[1] && !reg_rdata[0])
    else $error("fixed status bits wrong");
  read_clear_a: assert property ((rd_st && !ovf) ##1 !ovf ##1 (rd_st && !ovf)
    |=> !reg_rdata[5])
    else $error("overflow flag not cleared by read");

  detect_c: cover property (rd_st ##1 reg_rdata[7]);
  drift_c: cover property (rd_st ##1 reg_rdata[6]);
  hb_off_c: cover property (blanking && !heartbeat_enable);
endmodule

/* testbench/video_source_model.sv */
/*
  Camera side pixel clock source: one event every div cycles while on.
  Assumes div of at least 1; lock follows on, the receiver having no slack.
*/
`timescale 1ns/1ps
module video_source_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic on,
  input wire logic [7:0] div,
  output logic pclk_event,
  output logic pclk_lock
);
  logic [7:0] cnt_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      pclk_event <= 1'b0;
    end else begin
      // restart on reaching div so a rate change takes hold within one period
      cnt_q <= (cnt_q + 8'h01 >= div) ? 8'h00 : cnt_q + 8'h01;
      pclk_event <= on && cnt_q == 8'h00;
    end
  end
  assign pclk_lock = on;
endmodule

/* testbench/video_tx_status_monitor_tb_top.sv */
/*
  Self-checking bench of the status monitor: register accesses, pixel clock
  source model, FIFO and packet stimulus. Assumes an 8 ns sys_clk.
*/
`timescale 1ns/1ps
module video_tx_status_monitor_tb_top;
  import video_tx_status_pkg::*;
  localparam int GATE_CYC = 250;
  localparam int FIFO_DEP = 256;
  localparam logic [11:0] ST = VIDEO_TX_STATUS_ADDR;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic on = 1'b0;
  logic [7:0] div = 8'h0A;
  logic pclk_event;
  logic pclk_lock;
  logic pipeline_running = 1'b0;
  logic blanking = 1'b0;
  logic tunnel_mode = 1'b0;
  logic phy_packet = 1'b0;
  logic protocol_packet = 1'b0;
  logic tunnel_packet = 1'b0;
  logic fifo_push = 1'b0;
  logic fifo_full = 1'b0;
  logic [8:0] fifo_level = 9'h000;
  logic heartbeat_enable;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [7:0] cnt_exp [3] = '{8'h03, 8'h02, 8'h02};

  video_tx_status_monitor #(.GATE_CYC(GATE_CYC), .FIFO_DEP(FIFO_DEP)) video_tx_status_monitor_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pclk_event(pclk_event),
    .pclk_lock(pclk_lock), .pipeline_running(pipeline_running), .blanking(blanking),
    .tunnel_mode(tunnel_mode), .phy_packet(phy_packet), .protocol_packet(protocol_packet),
    .tunnel_packet(tunnel_packet), .fifo_push(fifo_push), .fifo_full(fifo_full),
    .fifo_level(fifo_level), .heartbeat_enable(heartbeat_enable));
  video_source_model video_source_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .on(on),
    .div(div), .pclk_event(pclk_event), .pclk_lock(pclk_lock));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    cyc(1);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    cyc(1);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic [7:0] msk);
    cyc(1);
    reg_rd <= 1'b1;
    reg_addr <= a;
    cyc(1);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), exp, reg_rdata & msk);
  endtask

  initial begin
    cyc(2);
    rst_n <= 1'b1;
    rd(ST, 8'h0A, 8'hFF);
    rd(12'h3FF, 8'h00, 8'hFF);
    wr(ST, 8'hFF);
    rd(ST, 8'h0E, 8'hFF);
    for (int v = 1; v >= 0; v--) begin
      wr(ST, {5'h00, v[0], 2'h0});
      blanking <= 1'b1;
      cyc(3);
      #1;
      chk("heartbeat", {7'h00, !v[0]}, {7'h00, heartbeat_enable});
      cyc(1);
      blanking <= 1'b0;
      // far side counts missing beats outside blanking, so they must resume
      cyc(2);
      #1;
      chk("heartbeat", 8'h01, {7'h00, heartbeat_enable});
    end
    // 250-cycle gate: 6 or 7 events stays under the 8 threshold, 25 passes it
    div <= 8'h28;
    on <= 1'b1;
    cyc(600);
    rd(ST, 8'h00, 8'h80);
    cyc(1);
    div <= 8'h0A;
    cyc(600);
    rd(ST, 8'h80, 8'h80);
    cyc(1);
    tunnel_mode <= 1'b1;
    cyc(600);
    rd(ST, 8'h80, 8'h80);
    cyc(1);
    on <= 1'b0;
    tunnel_mode <= 1'b0;
    cyc(3);
    rd(ST, 8'h00, 8'h80);
    cyc(1);
    on <= 1'b1;
    pipeline_running <= 1'b1;
    cyc(900);
    rd(ST, 8'h00, 8'h40);
    cyc(1);
    div <= 8'h0C;
    cyc(600);
    rd(ST, 8'h40, 8'h40);
    // drift re-raises each window until restart, even after a read
    cyc(300);
    pipeline_running <= 1'b0;
    div <= 8'h0A;
    cyc(600);
    rd(ST, 8'h40, 8'h40);
    rd(ST, 8'h00, 8'h40);
    cyc(1);
    pipeline_running <= 1'b1;
    cyc(600);
    rd(ST, 8'h00, 8'h40);
    cyc(1);
    fifo_push <= 1'b1;
    fifo_full <= 1'b1;
    cyc(1);
    fifo_push <= 1'b0;
    fifo_full <= 1'b0;
    rd(ST, 8'h20, 8'h20);
    rd(ST, 8'h00, 8'h20);
    cyc(1);
    fifo_level <= 9'h081;
    rd(ST, 8'h10, 8'h10);
    cyc(1);
    fifo_level <= 9'h080;
    rd(ST, 8'h10, 8'h10);
    rd(ST, 8'h00, 8'h10);
    // first tunnel pulse falls outside tunnel mode and must not count
    for (int i = 0; i < 3; i++) begin
      cyc(1);
      phy_packet <= 1'b1;
      protocol_packet <= i < 2;
      tunnel_packet <= 1'b1;
      tunnel_mode <= i != 0;
      cyc(1);
      phy_packet <= 1'b0;
      protocol_packet <= 1'b0;
      tunnel_packet <= 1'b0;
    end
    for (int i = 0; i < 3; i++) begin
      rd(12'(PKT_CNT_BASE_ADDR + 2 * i), cnt_exp[i], 8'hFF);
      rd(12'(PKT_CNT_BASE_ADDR + 2 * i + 1), 8'h00, 8'hFF);
    end
    end_of_test();
  end
endmodule

bind video_tx_status_monitor video_tx_status_monitor_checker #(.GATE_CYC(GATE_CYC),
  .FIFO_DEP(FIFO_DEP)) chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pclk_lock(pclk_lock), .blanking(blanking), .fifo_push(fifo_push), .fifo_full(fifo_full),
  .fifo_level(fifo_level), .heartbeat_enable(heartbeat_enable));
